// ==== acc_analog_comparator_control.sv ====
// Control, event and AXI4-Lite register logic around an analog comparator
// Behaviour
// - Enable bit runs the comparator and its event logic; example image is 0xB3.
// - Reference-select clear picks the external input instead of the bandgap.
// - One input may be compared against the internal reference voltage.
// - Edge mode 11 sets the event flag on rising or falling output edges.
// - Output-pin enable clear keeps result off the pin; set drives it while the enable bit is set.
// - Option bit routes comparator output to timer capture channel 0.
// - With interrupt enable set, each selected-edge crossing raises an interrupt.
// - Interrupt is delivered with its own dedicated vector number 20.
`include "acc_params.svh"
module acc_analog_comparator_control (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compareRaw,
  output logic comparatorPowerOn,
  output logic bandgapSelect,
  output logic outputPinData,
  output logic outputPinEnable,
  output logic captureChannel0,
  output logic compareIrq,
  output logic [7:0] compareIrqVector
);
  logic [7:0] csr_r, csr_nxt;
  logic capRoute_r, capRoute_nxt;
  logic syncA_r, syncB_r, syncC_r;
  logic [2:0] sync_nxt;
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [7:0] wData_r, wData_nxt;
  logic wLane_r, wLane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic pinData_r, pinEn_r, cap_r, irq_r;
  logic [7:0] vec_r;
  logic pinData_nxt, pinEn_nxt, cap_nxt, irq_nxt;
  logic [7:0] vec_nxt;
  logic awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt, arRdy_r, arRdy_nxt;
  logic edgeHit, doWrite, rise, fall;

  function automatic logic [1:0] acc_decode(input logic [7:0] a);
    if (a == `ACC_CSR_OFFSET) acc_decode = 2'b01;
    else if (a == `ACC_OPT_OFFSET) acc_decode = 2'b10;
    else acc_decode = 2'b00;
  endfunction : acc_decode

  // Two flops resynchronise the raw result; the third only feeds the edge detector
  always_comb begin
    sync_nxt = {syncB_r, syncA_r, compareRaw};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      syncC_r <= 1'b0;
    end else begin
      syncA_r <= sync_nxt[0];
      syncB_r <= sync_nxt[1];
      syncC_r <= sync_nxt[2];
    end
  end

  assign rise = syncB_r & ~syncC_r;
  assign fall = ~syncB_r & syncC_r;

  always_comb begin
    edgeHit = 1'b0;
    if (csr_r[`ACC_BIT_ENABLE]) begin
      unique case (acc_pkg::acc_edge_t'(csr_r[`ACC_BIT_MOD_HI:`ACC_BIT_MOD_LO]))
        acc_pkg::ACC_EDGE_FALL: edgeHit = fall;
        acc_pkg::ACC_EDGE_RISE: edgeHit = rise;
        acc_pkg::ACC_EDGE_RSVD: edgeHit = fall;
        acc_pkg::ACC_EDGE_ANY: edgeHit = rise | fall;
      endcase
    end
  end

  // AXI write: address and data may arrive in either order
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;

  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wLane_nxt = wLane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    csr_nxt = csr_r;
    capRoute_nxt = capRoute_r;
    if (s_axi_awvalid && !awHeld_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !wHeld_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata[7:0];
      wLane_nxt = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (acc_decode(awAddr_r) == 2'b00) ? 2'b10 : 2'b00;
      if (wLane_r && acc_decode(awAddr_r) == 2'b01) begin
        csr_nxt[`ACC_BIT_ENABLE] = wData_r[`ACC_BIT_ENABLE];
        csr_nxt[`ACC_BIT_BGSEL] = wData_r[`ACC_BIT_BGSEL];
        csr_nxt[`ACC_BIT_IE] = wData_r[`ACC_BIT_IE];
        csr_nxt[`ACC_BIT_OPE] = wData_r[`ACC_BIT_OPE];
        csr_nxt[`ACC_BIT_MOD_HI:`ACC_BIT_MOD_LO] = wData_r[`ACC_BIT_MOD_HI:`ACC_BIT_MOD_LO];
        if (wData_r[`ACC_BIT_FLAG]) csr_nxt[`ACC_BIT_FLAG] = 1'b0;
      end
      if (wLane_r && acc_decode(awAddr_r) == 2'b10) begin
        capRoute_nxt = wData_r[`ACC_BIT_CAPROUTE];
      end
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    // A new event wins over a clear in the same cycle
    if (edgeHit) csr_nxt[`ACC_BIT_FLAG] = 1'b1;
    csr_nxt[`ACC_BIT_OUT] = syncB_r;
    // Ready lines leave flops, mirroring the next held state
    awRdy_nxt = !awHeld_nxt;
    wRdy_nxt = !wHeld_nxt;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 8'h00;
      wLane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      csr_r <= `ACC_CSR_RESET;
      capRoute_r <= 1'b0;
      awRdy_r <= 1'b1;
      wRdy_r <= 1'b1;
    end else begin
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wLane_r <= wLane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      csr_r <= csr_nxt;
      capRoute_r <= capRoute_nxt;
      awRdy_r <= awRdy_nxt;
      wRdy_r <= wRdy_nxt;
    end
  end

  // AXI read: one outstanding, answered the cycle after the address is taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'b00;
      unique case (acc_decode(s_axi_araddr[7:0]))
        2'b01: rdata_nxt = {24'h00_0000, csr_r};
        2'b10: rdata_nxt = {31'h0000_0000, capRoute_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = 2'b10;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arRdy_nxt = !rvalid_nxt;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rresp_r <= 2'b00;
      rdata_r <= 32'h0000_0000;
      arRdy_r <= 1'b1;
    end else begin
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      arRdy_r <= arRdy_nxt;
    end
  end

  // Pin-side values follow the next register image, so pins move with the CSR
  // Pin drive is blanked while the comparator is off
  always_comb begin
    pinEn_nxt = csr_nxt[`ACC_BIT_ENABLE] & csr_nxt[`ACC_BIT_OPE];
    pinData_nxt = csr_nxt[`ACC_BIT_OPE] & syncB_r;
    cap_nxt = capRoute_nxt & syncB_r;
    irq_nxt = csr_nxt[`ACC_BIT_FLAG] & csr_nxt[`ACC_BIT_IE];
    vec_nxt = `ACC_VECTOR;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinData_r <= 1'b0;
      pinEn_r <= 1'b0;
      cap_r <= 1'b0;
      irq_r <= 1'b0;
      vec_r <= 8'h00;
    end else begin
      pinEn_r <= pinEn_nxt;
      pinData_r <= pinData_nxt;
      cap_r <= cap_nxt;
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
    end
  end

  assign s_axi_awready = awRdy_r;
  assign s_axi_wready = wRdy_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign comparatorPowerOn = csr_r[`ACC_BIT_ENABLE];
  assign bandgapSelect = csr_r[`ACC_BIT_BGSEL];
  assign outputPinData = pinData_r;
  assign outputPinEnable = pinEn_r;
  assign captureChannel0 = cap_r;
  assign compareIrq = irq_r;
  assign compareIrqVector = vec_r;

  property p_any_edge;
    @(posedge ref_clk) disable iff (!rstn)
      (csr_r[`ACC_BIT_ENABLE] && csr_r[1:0] == 2'b11 && (rise || fall)) |=> csr_r[`ACC_BIT_FLAG];
  endproperty
  a_flag_any_edge: assert property (p_any_edge) else $error("edge did not set flag");

  a_flag_off_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!csr_r[`ACC_BIT_ENABLE] && !csr_r[`ACC_BIT_FLAG] && !doWrite) |=> !csr_r[`ACC_BIT_FLAG])
    else $error("flag set while disabled");

  a_irq_follows_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    (csr_r[`ACC_BIT_FLAG] && csr_r[`ACC_BIT_IE]) |-> compareIrq)
    else $error("irq missing");

  a_irq_needs_ie: assert property (@(posedge ref_clk) disable iff (!rstn)
    compareIrq |-> $past(csr_nxt[`ACC_BIT_IE]))
    else $error("irq without enable");

  a_pin_off_ope: assert property (@(posedge ref_clk) disable iff (!rstn)
    !csr_r[`ACC_BIT_OPE] |-> (!outputPinData && !outputPinEnable))
    else $error("pin driven while disabled");

  a_cap_route: assert property (@(posedge ref_clk) disable iff (!rstn)
    (capRoute_r && $stable(capRoute_r)) |-> captureChannel0 == $past(syncB_r))
    else $error("capture route wrong");

  a_out_status: assert property (@(posedge ref_clk) disable iff (!rstn)
    csr_r[`ACC_BIT_OUT] == $past(syncB_r))
    else $error("status not synchronized result");

  sequence s_clear_write;
    doWrite && wLane_r && acc_decode(awAddr_r) == 2'b01 && wData_r[`ACC_BIT_FLAG] && !edgeHit;
  endsequence
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_clear_write |=> !csr_r[`ACC_BIT_FLAG])
    else $error("flag not cleared");

  // Rising-only mode must not flag a falling crossing
  a_rise_only: assert property (@(posedge ref_clk) disable iff (!rstn)
    (csr_r[`ACC_BIT_ENABLE] && csr_r[1:0] == 2'b01 && !csr_r[`ACC_BIT_FLAG] && fall && !doWrite)
      |=> !csr_r[`ACC_BIT_FLAG])
    else $error("flag set on unselected edge");

  a_vector_const: assert property (@(posedge ref_clk) disable iff (!rstn)
    compareIrq |-> compareIrqVector == `ACC_VECTOR)
    else $error("wrong vector");

  sequence s_csr_write;
    doWrite && wLane_r && acc_decode(awAddr_r) == 2'b01;
  endsequence
  a_bgsel_port: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_csr_write |=> bandgapSelect == $past(wData_r[`ACC_BIT_BGSEL]))
    else $error("reference select mismatch");
endmodule : acc_analog_comparator_control

// ==== acc_analog_source.sv ====
// Behavioural analog front end: two input voltages or the bandgap reference
module acc_analog_source #(
  parameter logic [11:0] BANDGAP_MV = 12'h4B0
) (
  input wire logic [11:0] plusMv,
  input wire logic [11:0] minusMv,
  input wire logic powerOn,
  input wire logic bandgapSelect,
  output logic compareRaw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] refMv;
  // Bandgap replaces the inverting input when selected
  assign refMv = bandgapSelect ? BANDGAP_MV : minusMv;
  // Unpowered comparator rests low instead of tracking the inputs
  assign compareRaw = powerOn && (plusMv > refMv);
endmodule : acc_analog_source

// ==== acc_params.svh ====
// Offsets, field positions, reset values and vector number for the comparator control block
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_CSR_OFFSET 8'h00
`define ACC_OPT_OFFSET 8'h04
`define ACC_CSR_RESET 8'h00
`define ACC_CFG_EXAMPLE 8'hB3
`define ACC_BIT_ENABLE 7
`define ACC_BIT_BGSEL 6
`define ACC_BIT_FLAG 5
`define ACC_BIT_IE 4
`define ACC_BIT_OUT 3
`define ACC_BIT_OPE 2
`define ACC_BIT_MOD_HI 1
`define ACC_BIT_MOD_LO 0
`define ACC_BIT_CAPROUTE 0
`define ACC_VECTOR 8'h14
`endif

// ==== acc_pkg.sv ====
// Types for the comparator control block
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_EDGE_FALL = 2'b00,
    ACC_EDGE_RISE = 2'b01,
    ACC_EDGE_RSVD = 2'b10,
    ACC_EDGE_ANY = 2'b11
  } acc_edge_t;
endpackage : acc_pkg

// ==== analog_comparator_control_bench.sv ====
// Self-checking bench for the comparator control block
`include "acc_params.svh"
module analog_comparator_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] awAddr = 32'h0000_0000, wData = 32'h0000_0000, arAddr = 32'h0000_0000;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, rd;
  logic [11:0] plusMv = 12'h000, minusMv = 12'h5DC;
  logic compareRaw, powerOn, bgSel, pinData, pinEn, capture, irq;
  logic [7:0] vector;
  int fail_count = 0;
  int num_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  acc_analog_comparator_control dut (.ref_clk(ref_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .compareRaw(compareRaw), .comparatorPowerOn(powerOn), .bandgapSelect(bgSel),
    .outputPinData(pinData), .outputPinEnable(pinEn), .captureChannel0(capture),
    .compareIrq(irq), .compareIrqVector(vector));
  acc_analog_source analog (.plusMv(plusMv), .minusMv(minusMv), .powerOn(powerOn),
    .bandgapSelect(bgSel), .compareRaw(compareRaw));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  // Address and data are offered together; each is dropped once taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    awAddr <= 32'(a);
    wData <= 32'(d);
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    resp = bResp;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    arAddr <= 32'(a);
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    rd = rData;
    resp = rResp;
  endtask : axr
  task automatic t_config;
    axr(`ACC_CSR_OFFSET);
    chk(rd, 32'(`ACC_CSR_RESET), "csr reset");
    chk({powerOn, irq, pinEn, capture}, 4'h0, "idle outputs");
    axw(`ACC_CSR_OFFSET, `ACC_CFG_EXAMPLE);
    chk(resp, 2'b00, "write okay");
    axr(`ACC_CSR_OFFSET);
    chk(rd, 32'h0000_0093, "config image");
    chk({powerOn, bgSel, pinEn}, 3'b100, "external reference");
    $display("config test done");
  endtask : t_config
  task automatic t_edges;
    plusMv <= 12'hBB8;
    settle(8);
    chk({irq, vector}, {1'b1, `ACC_VECTOR}, "rising event");
    axr(`ACC_CSR_OFFSET);
    chk(rd, 32'h0000_00BB, "flag and status");
    axw(`ACC_CSR_OFFSET, `ACC_CFG_EXAMPLE);
    settle(2);
    chk(irq, 1'b0, "flag cleared");
    @(posedge ref_clk);
    plusMv <= 12'h000;
    settle(8);
    chk(irq, 1'b1, "falling event");
    axw(`ACC_CSR_OFFSET, `ACC_CFG_EXAMPLE);
    $display("edge test done");
  endtask : t_edges
  task automatic t_pin;
    axw(`ACC_CSR_OFFSET, 8'h9F);
    axr(`ACC_CSR_OFFSET);
    chk(rd, 32'h0000_0097, "status bit read only");
    chk({pinEn, pinData}, 2'b10, "pin driven low");
    plusMv <= 12'hBB8;
    settle(8);
    chk(pinData, 1'b1, "pin follows result");
    axw(`ACC_OPT_OFFSET, 8'h01);
    axr(`ACC_OPT_OFFSET);
    chk(rd, 32'h0000_0001, "route bit readback");
    settle(4);
    chk(capture, 1'b1, "capture routed");
    axw(`ACC_OPT_OFFSET, 8'h00);
    settle(4);
    chk(capture, 1'b0, "capture unrouted");
    $display("pin and route test done");
  endtask : t_pin
  task automatic t_bandgap;
    @(posedge ref_clk);
    minusMv <= 12'h000;
    plusMv <= 12'h3E8;
    axw(`ACC_CSR_OFFSET, 8'hC3);
    settle(6);
    chk(bgSel, 1'b1, "bandgap selected");
    axr(`ACC_CSR_OFFSET);
    chk(rd[3], 1'b0, "below bandgap");
    plusMv <= 12'h5DC;
    settle(6);
    axr(`ACC_CSR_OFFSET);
    chk(rd[3], 1'b1, "above bandgap");
    axr(8'h10);
    chk(resp, 2'b10, "unmapped read response");
    chk(rd, 32'h0000_0000, "unmapped read data");
    axw(8'h10, 8'hFF);
    chk(resp, 2'b10, "unmapped write");
    $display("bandgap and map test done");
  endtask : t_bandgap
  // Single-edge modes must let the opposite edge pass without an event
  task automatic t_modes;
    axw(`ACC_CSR_OFFSET, 8'hB1);
    settle(2);
    chk(irq, 1'b0, "rise mode armed");
    @(posedge ref_clk);
    plusMv <= 12'h000;
    settle(8);
    chk(irq, 1'b0, "fall ignored in rise mode");
    axw(`ACC_CSR_OFFSET, 8'h90);
    plusMv <= 12'hBB8;
    settle(8);
    chk(irq, 1'b0, "rise ignored in fall mode");
    @(posedge ref_clk);
    plusMv <= 12'h000;
    settle(8);
    chk(irq, 1'b1, "fall mode event");
    $display("edge mode test done");
  endtask : t_modes
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    t_config;
    t_edges;
    t_pin;
    t_bandgap;
    t_modes;
    end_of_test;
  end
  // Whole run needs under 200 cycles; this cuts a hung handshake
  initial begin
    #50000;
    fail_count++;
    end_of_test;
  end
endmodule : analog_comparator_control_bench
